// File: logic/sla_regs.svh
// constants for the shift-left-arithmetic datapath slice
`ifndef SLA_REGS_SVH
`define SLA_REGS_SVH
`define SLA_PREFIX_CB     8'hcb
`define SLA_PREFIX_IDX0   8'hdd
`define SLA_PREFIX_IDX1   8'hfd
`define SLA_OP_HI         5'h04
`define SLA_REG_MEM       3'h6
`define SLA_FLAG_C        0
`define SLA_FLAG_N        1
`define SLA_FLAG_PV       2
`define SLA_FLAG_H        4
`define SLA_FLAG_Z        6
`define SLA_FLAG_S        7
`define SLA_FLAGS_RST     8'h00
`endif

// File: logic/sla_pkg.sv
// types for the shift-left-arithmetic datapath slice
package sla_pkg;
  typedef enum logic [1:0] {
    SLA_ST_IDLE = 2'b00,
    SLA_ST_CB   = 2'b01,
    SLA_ST_DISP = 2'b11,
    SLA_ST_IXCB = 2'b10
  } sla_state_t;

  typedef enum logic [1:0] {
    SLA_SRC_REG  = 2'h0,
    SLA_SRC_PTR  = 2'h1,
    SLA_SRC_IDX0 = 2'h2,
    SLA_SRC_IDX1 = 2'h3
  } sla_src_t;

  typedef struct packed {
    logic       valid;
    sla_src_t   src;
    logic [2:0] reg_sel;
    logic [7:0] disp;
  } sla_decode_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] result;
    logic [7:0] flags;
  } sla_result_t;
endpackage : sla_pkg

// File: logic/sla_shift_core.sv
// combinational shift and flag generation
`timescale 1ns/1ps
`include "sla_regs.svh"
module sla_shift_core
  import sla_pkg::*;
(
  input  wire logic [7:0] operand,
  output logic      [7:0] result,
  output logic      [7:0] flags
);
  always_comb begin
    result = {operand[6:0], 1'b0};
    flags = `SLA_FLAGS_RST;
    flags[`SLA_FLAG_C]  = operand[7];
    flags[`SLA_FLAG_S]  = result[7];
    flags[`SLA_FLAG_Z]  = (result == 8'h00);
    flags[`SLA_FLAG_H]  = 1'b0;
    flags[`SLA_FLAG_N]  = 1'b0;
    flags[`SLA_FLAG_PV] = ~(^result);
  end
endmodule : sla_shift_core

// File: logic/sla_unit.sv
// opcode decode and registered shift datapath
`timescale 1ns/1ps
`include "sla_regs.svh"
// Notes on behaviour
// - result is operand shifted left one place, zero into bit 0.
// - carry takes the operand's old bit 7.
// - sign flag copies result bit 7.
// - zero flag set on all-zero result; half-carry and subtract cleared.
// - parity/overflow flag set when the result has even parity.
// - prefix then 00 100 r selects register; r=110 selects pointer-pair memory.
// - index prefix, shift prefix, displacement, final 00 100 110; bit selects index.
module sla_unit
  import sla_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        op_valid,
  input  wire logic [7:0]  op_byte,
  input  wire logic        operand_valid,
  input  wire logic [7:0]  operand_data,
  output sla_decode_t      dec_q,
  output logic             illegal_q,
  output sla_result_t      res_q,
  output sla_src_t         wb_src_q,
  output logic [2:0]       wb_reg_q,
  output logic [7:0]       wb_disp_q
);
  // ----------------------------------------
  // opcode decode
  // ----------------------------------------
  sla_state_t  state_q, state_d;
  logic        idx_sel_q, idx_sel_d;
  logic [7:0]  disp_q, disp_d;
  sla_decode_t dec_d;
  logic        illegal_d;
  logic        busy_q, busy_d;

  always_comb begin
    state_d   = state_q;
    idx_sel_d = idx_sel_q;
    disp_d    = disp_q;
    dec_d     = '0;
    illegal_d = 1'b0;
    if (op_valid) begin
      case (state_q)
        SLA_ST_IDLE: begin
          if (op_byte == `SLA_PREFIX_CB) begin
            state_d = SLA_ST_CB;
          end else if (op_byte == `SLA_PREFIX_IDX0 || op_byte == `SLA_PREFIX_IDX1) begin
            state_d   = SLA_ST_IXCB;
            idx_sel_d = op_byte[5];
          end else begin
            illegal_d = 1'b1;
          end
        end
        SLA_ST_CB: begin
          state_d = SLA_ST_IDLE;
          if (op_byte[7:3] == `SLA_OP_HI) begin
            dec_d.valid   = 1'b1;
            dec_d.reg_sel = op_byte[2:0];
            dec_d.src     = (op_byte[2:0] == `SLA_REG_MEM) ? SLA_SRC_PTR : SLA_SRC_REG;
          end else begin
            illegal_d = 1'b1;
          end
        end
        SLA_ST_IXCB: begin
          if (op_byte == `SLA_PREFIX_CB) begin
            state_d = SLA_ST_DISP;
          end else begin
            state_d   = SLA_ST_IDLE;
            illegal_d = 1'b1;
          end
        end
        SLA_ST_DISP: begin
          // displacement byte first, then the final opcode byte;
          // any byte value is a legal displacement, so only busy_q steers
          if (!busy_q) begin
            disp_d = op_byte;
          end else begin
            state_d = SLA_ST_IDLE;
            if (op_byte == {`SLA_OP_HI, `SLA_REG_MEM}) begin
              dec_d.valid = 1'b1;
              dec_d.src   = idx_sel_q ? SLA_SRC_IDX1 : SLA_SRC_IDX0;
              dec_d.disp  = disp_q;
            end else begin
              illegal_d = 1'b1;
            end
          end
        end
        default: state_d = SLA_ST_IDLE;
      endcase
    end
  end

  // busy_q marks that the displacement byte has been taken
  // clear: next byte is the displacement; set: next byte is the final opcode
  // a stalled stream (op_valid low) keeps the toggle where it is
  always_comb begin
    busy_d = busy_q;
    if (state_q != SLA_ST_DISP) begin
      busy_d = 1'b0;
    end else if (op_valid) begin
      busy_d = ~busy_q;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q   <= SLA_ST_IDLE;
      idx_sel_q <= 1'b0;
      disp_q    <= 8'h00;
      busy_q    <= 1'b0;
      dec_q     <= '0;
      illegal_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      idx_sel_q <= idx_sel_d;
      disp_q    <= disp_d;
      busy_q    <= busy_d;
      dec_q     <= dec_d;
      illegal_q <= illegal_d;
    end
  end

  // ----------------------------------------
  // execute and write-back target
  // ----------------------------------------
  logic [7:0]  core_res;
  logic [7:0]  core_flags;
  sla_src_t    tgt_src_q, tgt_src_d;
  logic [2:0]  tgt_reg_q, tgt_reg_d;
  logic [7:0]  tgt_disp_q, tgt_disp_d;
  sla_result_t res_d;
  sla_src_t    wb_src_d;
  logic [2:0]  wb_reg_d;
  logic [7:0]  wb_disp_d;

  sla_shift_core u_core (
    .operand (operand_data),
    .result  (core_res),
    .flags   (core_flags)
  );

  // ----------------------------------------
  // flag byte assembly
  // ----------------------------------------
  // rebuilt bit by bit so unused flag positions always read as zero
  logic [7:0]  flag_byte;

  always_comb begin
    flag_byte                 = `SLA_FLAGS_RST;
    flag_byte[`SLA_FLAG_C]  = core_flags[`SLA_FLAG_C];
    flag_byte[`SLA_FLAG_S]  = core_flags[`SLA_FLAG_S];
    flag_byte[`SLA_FLAG_Z]  = core_flags[`SLA_FLAG_Z];
    flag_byte[`SLA_FLAG_H]  = 1'b0;
    flag_byte[`SLA_FLAG_N]  = 1'b0;
    flag_byte[`SLA_FLAG_PV] = core_flags[`SLA_FLAG_PV];
  end

  // ----------------------------------------
  // result and write-back registers
  // ----------------------------------------
  // the operand location latched at decode is where the result returns
  // limitation: an operand given before the target latches uses the old target
  always_comb begin
    tgt_src_d  = tgt_src_q;
    tgt_reg_d  = tgt_reg_q;
    tgt_disp_d = tgt_disp_q;
    if (dec_q.valid) begin
      tgt_src_d  = dec_q.src;
      tgt_reg_d  = dec_q.reg_sel;
      tgt_disp_d = dec_q.disp;
    end
    res_d        = '0;
    res_d.valid  = operand_valid;
    res_d.result = core_res;
    res_d.flags  = flag_byte;
    wb_src_d     = operand_valid ? tgt_src_q  : wb_src_q;
    wb_reg_d     = operand_valid ? tgt_reg_q  : wb_reg_q;
    wb_disp_d    = operand_valid ? tgt_disp_q : wb_disp_q;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tgt_src_q  <= SLA_SRC_REG;
      tgt_reg_q  <= 3'h0;
      tgt_disp_q <= 8'h00;
      res_q      <= '0;
      wb_src_q   <= SLA_SRC_REG;
      wb_reg_q   <= 3'h0;
      wb_disp_q  <= 8'h00;
    end else begin
      tgt_src_q  <= tgt_src_d;
      tgt_reg_q  <= tgt_reg_d;
      tgt_disp_q <= tgt_disp_d;
      res_q      <= res_d;
      wb_src_q   <= wb_src_d;
      wb_reg_q   <= wb_reg_d;
      wb_disp_q  <= wb_disp_d;
    end
  end
endmodule : sla_unit

// File: tb/sla_unit_props.sv
// port assertions for the shift unit
`timescale 1ns/1ps
module sla_unit_props
  import sla_pkg::*;
(
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        op_valid,
  input wire logic [7:0]  op_byte,
  input wire logic        operand_valid,
  input wire logic [7:0]  operand_data,
  input wire sla_decode_t dec_q,
  input wire sla_result_t res_q,
  input wire sla_src_t    wb_src_q,
  input wire logic [2:0]  wb_reg_q
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // a cb that follows an index prefix would alias, so demand a non-prefix byte first
  sequence s_reg;
    (op_byte != 8'hdd && op_byte != 8'hfd) ##1 op_valid && op_byte == 8'hcb
      ##1 op_valid && op_byte[7:3] == 5'h04;
  endsequence
  sequence s_idx;
    op_valid && op_byte[7:6] == 2'h3 && op_byte[4:0] == 5'h1d
      ##1 op_valid && op_byte == 8'hcb ##1 op_valid ##1 op_valid && op_byte == 8'h26;
  endsequence
  a_shift_result: assert property (operand_valid |=> res_q.valid &&
    res_q.result == {$past(operand_data[6:0]), 1'b0}) else $error("bad shift result");
  a_carry_copy: assert property (operand_valid |=>
    res_q.flags[0] == $past(operand_data[7])) else $error("bad carry flag");
  a_sign_flag: assert property (res_q.valid |->
    res_q.flags[7] == res_q.result[7]) else $error("bad sign flag");
  a_zero_clear: assert property (res_q.valid |-> res_q.flags[6] == (res_q.result == 8'h00)
    && !res_q.flags[4] && !res_q.flags[1]) else $error("bad zero or cleared flags");
  a_parity_even: assert property (res_q.valid |->
    res_q.flags[2] == ~^res_q.result) else $error("bad parity flag");
  a_reg_decode: assert property (s_reg |=> dec_q.valid && dec_q.reg_sel == $past(op_byte[2:0])
    && dec_q.src == (($past(op_byte[2:0]) == 3'h6) ? SLA_SRC_PTR : SLA_SRC_REG))
    else $error("bad register decode");
  a_idx_decode: assert property (s_idx |=> dec_q.valid && dec_q.disp == $past(op_byte, 2)
    && dec_q.src == ($past(op_byte[5], 4) ? SLA_SRC_IDX1 : SLA_SRC_IDX0))
    else $error("bad indexed decode");
  a_wb_target: assert property (dec_q.valid ##1 operand_valid |=>
    wb_reg_q == $past(dec_q.reg_sel, 2) && wb_src_q == $past(dec_q.src, 2))
    else $error("bad write-back target");
endmodule : sla_unit_props

bind sla_unit sla_unit_props u_props (.mclk(mclk), .resetn(resetn), .op_valid(op_valid),
  .op_byte(op_byte), .operand_valid(operand_valid), .operand_data(operand_data),
  .dec_q(dec_q), .res_q(res_q), .wb_src_q(wb_src_q), .wb_reg_q(wb_reg_q));

// File: tb/sla_unit_test.sv
// self-checking bench for the shift unit
`timescale 1ns/1ps
module sla_unit_test;
  import sla_pkg::*;
  logic        mclk = 1'b0, resetn = 1'b0, op_valid = 1'b0, operand_valid = 1'b0;
  logic [7:0]  op_byte = 8'h00, operand_data = 8'h00, wb_disp_q;
  sla_decode_t dec_q;
  sla_result_t res_q;
  sla_src_t    wb_src_q;
  logic        illegal_q;
  logic [2:0]  wb_reg_q;
  int          err_count = 0, samples_checked = 0;
  always #2.5 mclk = ~mclk;
  sla_unit dut (.mclk(mclk), .resetn(resetn), .op_valid(op_valid), .op_byte(op_byte),
    .operand_valid(operand_valid), .operand_data(operand_data), .dec_q(dec_q),
    .illegal_q(illegal_q), .res_q(res_q), .wb_src_q(wb_src_q), .wb_reg_q(wb_reg_q),
    .wb_disp_q(wb_disp_q));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [16:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic put(input logic [7:0] b);
    @(negedge mclk);
    op_valid = 1'b1;
    op_byte  = b;
  endtask : put
  // operand is given one cycle after the decode pulse, the earliest allowed
  task automatic run(input logic [7:0] d, input sla_src_t s, input logic [2:0] r,
                     input logic [7:0] dp);
    logic [7:0] res;
    res = {d[6:0], 1'b0};
    @(negedge mclk);
    op_valid = 1'b0;
    chk("decode", {1'b1, s, r, dp}, 17'(dec_q));
    @(negedge mclk);
    operand_valid = 1'b1;
    operand_data  = d;
    @(negedge mclk);
    operand_valid = 1'b0;
    chk("result", {1'b1, res, res[7], res == 8'h00, 3'h0, ~^res, 1'b0, d[7]}, res_q);
    chk("target", {4'h0, s, r, dp}, {4'h0, wb_src_q, wb_reg_q, wb_disp_q});
  endtask : run
  task automatic test_reg;
    logic [7:0] v [8] = '{8'h80, 8'hb1, 8'h00, 8'h40, 8'h7f, 8'hff, 8'h01, 8'hc3};
    for (int r = 0; r < 8; r++) begin
      put(8'hcb);
      put({5'h04, 3'(r)});
      run(v[r], (r == 6) ? SLA_SRC_PTR : SLA_SRC_REG, 3'(r), 8'h00);
    end
    $display("test_reg done");
  endtask : test_reg
  task automatic test_illegal;
    put(8'hcb);
    put(8'h30);
    @(negedge mclk);
    op_valid = 1'b0;
    chk("illegal", 17'h2, {15'h0, illegal_q, dec_q.valid});
    $display("test_illegal done");
  endtask : test_illegal
  task automatic test_idx;
    // odd and even displacements back to back; indexed form has no register field
    logic [7:0] dv [4] = '{8'h03, 8'h80, 8'hfe, 8'h7f};
    for (int i = 0; i < 4; i++) begin
      put(i[0] ? 8'hfd : 8'hdd);
      put(8'hcb);
      put(dv[i]);
      put(8'h26);
      run(dv[i] ^ 8'h5a, i[0] ? SLA_SRC_IDX1 : SLA_SRC_IDX0, 3'h0, dv[i]);
    end
    $display("test_idx done");
  endtask : test_idx
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  // ----------------------------------------
  // sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (2) @(negedge mclk);
    resetn = 1'b1;
    test_reg();
    test_illegal();
    test_idx();
    report_and_stop();
  end
  initial begin
    #3000;
    err_count++;
    report_and_stop();
  end
endmodule : sla_unit_test
